//--- verilog/vha_params.svh
// Constants for the voltage harmonic distortion alarm
`ifndef VHA_PARAMS_SVH
`define VHA_PARAMS_SVH

// ----------------------------------------
// Spectrum layout
// ----------------------------------------
`define VHA_NUM_CH 3
`define VHA_FUND_IDX 5'h01
`define VHA_FIRST_HARM 5'h02
`define VHA_LAST_HARM 5'h1F

// ----------------------------------------
// Figures in units of 0.01 %
// ----------------------------------------
`define VHA_FULL_SCALE 10000
`define VHA_REL_NUM 97
`define VHA_REL_DEN 100
`define VHA_THR_MIN 10
`define VHA_THR_MAX 10000
`define VHA_THR_RST 14'h3E8
`define VHA_FIG_SAT 16'hFFFF

// ----------------------------------------
// Timing, given in ms and counted in measurement cycles
// ----------------------------------------
`define VHA_TIME_BASE_MS 5
`define VHA_DELAY_DEFAULT_MS 10000
`define VHA_DELAY_MAX_MS 1800000
`define VHA_DELAY_RST 19'(`VHA_DELAY_DEFAULT_MS / `VHA_TIME_BASE_MS)
`define VHA_DELAY_MAX (`VHA_DELAY_MAX_MS / `VHA_TIME_BASE_MS)

// ----------------------------------------
// Event log
// ----------------------------------------
`define VHA_LOG_DEPTH 12

// ----------------------------------------
// Register word addresses and fields
// ----------------------------------------
`define VHA_A_CTRL 4'h0
`define VHA_A_THR 4'h1
`define VHA_A_DELAY 4'h2
`define VHA_A_STATUS 4'h3
`define VHA_A_INT_STAT 4'h4
`define VHA_A_INT_MASK 4'h5
`define VHA_A_CNT_START 4'h6
`define VHA_A_CNT_ALARM 4'h7
`define VHA_A_CNT_BLOCK 4'h8
`define VHA_A_CNT_CLR 4'h9
`define VHA_A_FIG01 4'hA
`define VHA_A_FIG2 4'hB
`define VHA_A_LOG_SEL 4'hC
`define VHA_A_LOG_TIME 4'hD
`define VHA_A_LOG_EVT 4'hE
`define VHA_A_LOG_FIG 4'hF
`define VHA_CTRL_MAG 3
`define VHA_CTRL_EN 4
`define VHA_MODE_RST 3'h0

`endif

//--- verilog/vha_pkg.sv
// Types shared by the voltage harmonic distortion alarm
package vha_pkg;

    // ----------------------------------------
    // Sequencer, modes and condition codes
    // ----------------------------------------
    typedef enum logic [5:0] {
        VHA_ST_IDLE = 6'h01,
        VHA_ST_LOAD = 6'h02,
        VHA_ST_DIV = 6'h04,
        VHA_ST_SQRT = 6'h08,
        VHA_ST_CMP = 6'h10,
        VHA_ST_EVAL = 6'h20
    } vha_fsm_t;

    typedef enum logic [2:0] {
        VHA_MODE_ON = 3'h0,
        VHA_MODE_BLOCKED = 3'h1,
        VHA_MODE_TEST = 3'h2,
        VHA_MODE_TEST_BLK = 3'h3,
        VHA_MODE_OFF = 3'h4
    } vha_mode_t;

    typedef enum logic [1:0] {
        VHA_COND_NORMAL = 2'h0,
        VHA_COND_START = 2'h1,
        VHA_COND_ALARM = 2'h2,
        VHA_COND_BLOCKED = 2'h3
    } vha_cond_t;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] ch;
        logic [4:0] idx;
        logic [15:0] mag;
    } vha_spec_t;

    typedef struct packed {
        logic [31:0] stamp;
        logic [2:0] evt;
        logic [2:0][15:0] fig;
    } vha_log_t;

    typedef struct packed {
        logic [2:0] mode;
        logic mag_pwr;
        logic alarm_en;
        logic [13:0] thr;
        logic [18:0] delay;
        logic [2:0][39:0] harm_acc;
        logic [2:0][31:0] fund_acc;
        logic [2:0][39:0] harm_lat;
        logic [2:0][31:0] fund_lat;
        vha_fsm_t fsm;
        logic [1:0] ch;
        logic [4:0] bitn;
        logic [55:0] num;
        logic [15:0] quo;
        logic [15:0] root;
        logic [2:0][15:0] fig;
        logic [2:0] over;
        logic [2:0] keep;
        logic pickup;
        logic start;
        logic alarm;
        logic blocked;
        logic [2:0] pins;
        logic [18:0] timer;
        logic [2:0] int_stat;
        logic [2:0] int_mask;
        logic irq;
        logic [2:0][15:0] cnt;
        logic [3:0] log_sel;
        logic [3:0] log_wr;
        vha_log_t [11:0] log;
        logic [31:0] rdata;
    } vha_regs_t;

endpackage

//--- verilog/vha_monitor.sv
// Voltage harmonic distortion monitor with alarm timer, counters and event log
//
// Design decisions made here: the address map and the plain strobed port.
`include "vha_params.svh"

module vha_monitor (
    input logic REF_CLK_I,
    input logic RST_N_I,
    input logic SPEC_VALID_I,
    input vha_pkg::vha_spec_t SPEC_I,
    input logic SPEC_END_I,
    input logic BLOCK_I,
    input logic [31:0] TIME_I,
    input logic [3:0] ADDR_I,
    input logic [31:0] WDATA_I,
    input logic WR_I,
    input logic RD_I,
    output logic [31:0] RDATA_O,
    output logic START_O,
    output logic ALARM_O,
    output logic BLOCKED_O,
    output logic IRQ_O
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo,
                                          input logic [31:0] hi);
        if (v < lo) begin
            return lo;
        end
        if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

    // Counters stick at full scale rather than wrap to zero
    function automatic logic [15:0] inc16(input logic [15:0] v, input logic en);
        return (en && v != 16'hFFFF) ? v + 16'h0001 : v;
    endfunction

    localparam vha_pkg::vha_regs_t RST_VAL = '{
        mode: `VHA_MODE_RST,
        alarm_en: 1'b1,
        thr: `VHA_THR_RST,
        delay: `VHA_DELAY_RST,
        fsm: vha_pkg::VHA_ST_IDLE,
        default: '0
    };

    vha_pkg::vha_regs_t r;
    vha_pkg::vha_regs_t next;
    logic [31:0] sq;
    logic [55:0] dvsr;
    logic [15:0] trial;
    logic [2:0] rise;
    logic run;
    logic blk;
    logic pick_n;
    logic start_n;
    logic alarm_n;
    logic blocked_n;
    logic [18:0] elapsed;
    logic [4:0] li;
    logic [31:0] rd;
    logic [1:0] cond;

    always_comb begin
        next = r;
        sq = 32'(SPEC_I.mag) * 32'(SPEC_I.mag);
        dvsr = 56'(r.fund_lat[r.ch]) << r.bitn;
        trial = r.root | (16'h0001 << r.bitn[3:0]);
        rise = 3'h0;
        run = r.mode == vha_pkg::VHA_MODE_ON || r.mode == vha_pkg::VHA_MODE_BLOCKED
            || r.mode == vha_pkg::VHA_MODE_TEST || r.mode == vha_pkg::VHA_MODE_TEST_BLK;
        blk = BLOCK_I || r.mode == vha_pkg::VHA_MODE_BLOCKED
            || r.mode == vha_pkg::VHA_MODE_TEST_BLK;
        pick_n = 1'b0;
        start_n = 1'b0;
        alarm_n = 1'b0;
        blocked_n = 1'b0;
        elapsed = 19'h0;
        li = 5'(r.log_wr) + 5'(`VHA_LOG_DEPTH - 1) - 5'(r.log_sel);
        if (li >= 5'(`VHA_LOG_DEPTH)) begin
            li = li - 5'(`VHA_LOG_DEPTH);
        end
        cond = vha_pkg::VHA_COND_NORMAL;
        if (r.blocked) begin
            cond = vha_pkg::VHA_COND_BLOCKED;
        end else if (r.alarm) begin
            cond = vha_pkg::VHA_COND_ALARM;
        end else if (r.start) begin
            cond = vha_pkg::VHA_COND_START;
        end

        // ----------------------------------------
        // Register port
        // ----------------------------------------
        rd = 32'h0;
        unique case (ADDR_I)
            `VHA_A_CTRL: rd = {27'h0, r.alarm_en, r.mag_pwr, r.mode};
            `VHA_A_THR: rd = {18'h0, r.thr};
            `VHA_A_DELAY: rd = {13'h0, r.delay};
            `VHA_A_STATUS: rd = {23'h0, r.keep, r.over, r.pickup, cond};
            `VHA_A_INT_STAT: rd = {29'h0, r.int_stat};
            `VHA_A_INT_MASK: rd = {29'h0, r.int_mask};
            `VHA_A_CNT_START: rd = {16'h0, r.cnt[0]};
            `VHA_A_CNT_ALARM: rd = {16'h0, r.cnt[1]};
            `VHA_A_CNT_BLOCK: rd = {16'h0, r.cnt[2]};
            `VHA_A_FIG01: rd = {r.fig[1], r.fig[0]};
            `VHA_A_FIG2: rd = {16'h0, r.fig[2]};
            `VHA_A_LOG_SEL: rd = {28'h0, r.log_sel};
            `VHA_A_LOG_TIME: rd = r.log[li[3:0]].stamp;
            `VHA_A_LOG_EVT: rd = {r.log[li[3:0]].fig[2], 13'h0, r.log[li[3:0]].evt};
            `VHA_A_LOG_FIG: rd = {r.log[li[3:0]].fig[1], r.log[li[3:0]].fig[0]};
            default: rd = 32'h0;
        endcase
        // Read data stands for exactly one cycle
        next.rdata = RD_I ? rd : 32'h0;
        if (RD_I && ADDR_I == `VHA_A_INT_STAT) begin
            next.int_stat = 3'h0;
        end
        if (WR_I) begin
            unique case (ADDR_I)
                `VHA_A_CTRL: begin
                    next.mode = WDATA_I[2:0];
                    next.mag_pwr = WDATA_I[`VHA_CTRL_MAG];
                    next.alarm_en = WDATA_I[`VHA_CTRL_EN];
                end
                `VHA_A_THR: next.thr = 14'(clamp(WDATA_I, `VHA_THR_MIN, `VHA_THR_MAX));
                `VHA_A_DELAY: next.delay = 19'(clamp(WDATA_I, 0, `VHA_DELAY_MAX));
                `VHA_A_INT_MASK: next.int_mask = WDATA_I[2:0];
                `VHA_A_CNT_CLR: next.cnt = '0;
                `VHA_A_LOG_SEL: next.log_sel = 4'(clamp(WDATA_I, 0, `VHA_LOG_DEPTH - 1));
                default: begin
                end
            endcase
        end

        // ----------------------------------------
        // Spectrum accumulation
        // ----------------------------------------
        if (SPEC_VALID_I && SPEC_I.ch < 2'(`VHA_NUM_CH)) begin
            if (SPEC_I.idx == `VHA_FUND_IDX) begin
                next.fund_acc[SPEC_I.ch] = sq;
            end else if (SPEC_I.idx >= `VHA_FIRST_HARM && SPEC_I.idx <= `VHA_LAST_HARM) begin
                next.harm_acc[SPEC_I.ch] = r.harm_acc[SPEC_I.ch] + 40'(sq);
            end
        end
        if (SPEC_END_I) begin
            // A frame ending while the last one is still being worked is dropped
            if (r.fsm == vha_pkg::VHA_ST_IDLE) begin
                next.harm_lat = next.harm_acc;
                next.fund_lat = next.fund_acc;
                next.ch = 2'h0;
                next.fsm = vha_pkg::VHA_ST_LOAD;
            end
            next.harm_acc = '0;
            next.fund_acc = '0;
        end

        // ----------------------------------------
        // Ratio sequencer
        // ----------------------------------------
        unique case (r.fsm)
            vha_pkg::VHA_ST_IDLE: begin
            end
            vha_pkg::VHA_ST_LOAD: begin
                next.num = 56'(r.harm_lat[r.ch]) * 56'(`VHA_FULL_SCALE);
                next.quo = 16'h0;
                next.root = 16'h0;
                next.bitn = 5'h0F;
                next.fsm = vha_pkg::VHA_ST_DIV;
                if (r.fund_lat[r.ch] == 32'h0) begin
                    // No fundamental: report zero distortion
                    next.fig[r.ch] = 16'h0;
                    next.fsm = vha_pkg::VHA_ST_CMP;
                end else if (next.num >= {r.fund_lat[r.ch], 16'h0}) begin
                    // Overflow: one idle divide step keeps the saturated quotient
                    next.quo = `VHA_FIG_SAT;
                    next.num = 56'h0;
                    next.bitn = 5'h00;
                end
            end
            vha_pkg::VHA_ST_DIV: begin
                if (r.num >= dvsr) begin
                    next.num = r.num - dvsr;
                    next.quo[r.bitn[3:0]] = 1'b1;
                end
                if (r.bitn == 5'h00) begin
                    if (r.mag_pwr) begin
                        next.fig[r.ch] = next.quo;
                        next.fsm = vha_pkg::VHA_ST_CMP;
                    end else begin
                        next.num = 56'(next.quo) * 56'(`VHA_FULL_SCALE);
                        next.bitn = 5'h0F;
                        next.fsm = vha_pkg::VHA_ST_SQRT;
                    end
                end else begin
                    next.bitn = r.bitn - 5'h01;
                end
            end
            vha_pkg::VHA_ST_SQRT: begin
                if (56'(trial) * 56'(trial) <= r.num) begin
                    next.root = trial;
                end
                if (r.bitn == 5'h00) begin
                    next.fig[r.ch] = next.root;
                    next.fsm = vha_pkg::VHA_ST_CMP;
                end else begin
                    next.bitn = r.bitn - 5'h01;
                end
            end
            vha_pkg::VHA_ST_CMP: begin
                // Threshold is read here per channel, so a live change applies from the next channel compared, even mid-frame
                next.over[r.ch] = r.fig[r.ch] > 16'(r.thr);
                next.keep[r.ch] = 24'(r.fig[r.ch]) * 24'(`VHA_REL_DEN)
                    >= 24'(r.thr) * 24'(`VHA_REL_NUM);
                if (r.ch == 2'(`VHA_NUM_CH - 1)) begin
                    next.fsm = vha_pkg::VHA_ST_EVAL;
                end else begin
                    next.ch = r.ch + 2'h1;
                    next.fsm = vha_pkg::VHA_ST_LOAD;
                end
            end
            vha_pkg::VHA_ST_EVAL: begin
                if (run && r.alarm_en) begin
                    pick_n = r.pickup ? |r.keep : |r.over;
                end
                start_n = pick_n && !blk;
                blocked_n = pick_n && blk;
                if (r.start && r.timer < 19'(`VHA_DELAY_MAX)) begin
                    elapsed = r.timer + 19'h1;
                end else if (r.start) begin
                    elapsed = r.timer;
                end
                alarm_n = start_n && elapsed >= r.delay;
                next.timer = start_n ? elapsed : 19'h0;
                rise = {blocked_n && !r.blocked, alarm_n && !r.alarm, start_n && !r.start};
                next.pickup = pick_n;
                next.start = start_n;
                next.alarm = alarm_n;
                next.blocked = blocked_n;
                // Test modes run the element but keep the output pins quiet
                next.pins = (r.mode == vha_pkg::VHA_MODE_TEST
                    || r.mode == vha_pkg::VHA_MODE_TEST_BLK) ? 3'h0
                    : {blocked_n, alarm_n, start_n};
                for (int i = 0; i < 3; i++) begin
                    next.cnt[i] = inc16(next.cnt[i], rise[i]);
                end
                if (|rise) begin
                    next.log[r.log_wr].stamp = TIME_I;
                    next.log[r.log_wr].evt = rise;
                    next.log[r.log_wr].fig = r.fig;
                    next.log_wr = (r.log_wr == 4'(`VHA_LOG_DEPTH - 1)) ? 4'h0
                        : r.log_wr + 4'h1;
                end
                next.fsm = vha_pkg::VHA_ST_IDLE;
            end
            default: next.fsm = vha_pkg::VHA_ST_IDLE;
        endcase

        // ----------------------------------------
        // Interrupt: a new event beats a clearing read
        // ----------------------------------------
        next.int_stat = next.int_stat | rise;
        next.irq = |(next.int_stat & next.int_mask);
    end

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            r <= RST_VAL;
        end else begin
            r <= next;
        end
    end

    assign RDATA_O = r.rdata;
    assign START_O = r.pins[0];
    assign ALARM_O = r.pins[1];
    assign BLOCKED_O = r.pins[2];
    assign IRQ_O = r.irq;

endmodule

//--- tb/vha_fft_src.sv
// Behavioural spectrum source that plays one frame per request
module vha_fft_src (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [2:0][15:0] fund_i,
    input wire logic [2:0][31:0] harm_i,
    output logic vld_o,
    output vha_pkg::vha_spec_t spec_o,
    output logic end_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------
    // Frame player
    // ------------------------------
    task automatic put(input logic [1:0] c, input logic [4:0] i, input logic [15:0] m);
        @(posedge clk_i);
        vld_o <= 1'b1;
        spec_o <= {c, i, m};
    endtask
    initial begin
        vld_o = 1'b0;
        end_o = 1'b0;
        spec_o = 23'h2AAAAA;
        // One process owns every output, so each has a single driver
        forever begin
            @(posedge clk_i);
            if (!go_i) begin
                spec_o <= ~spec_o;  // Idle lines keep moving so stale data is never trusted
            end else begin
                for (int c = 0; c < 3; c++) begin
                    put(2'(c), 5'h00, 16'hFFFF);  // Unused bin, must be ignored
                    put(2'(c), 5'h02, harm_i[c][31:16]);
                    put(2'(c), 5'h1F, harm_i[c][15:0]);
                    put(2'(c), 5'h01, fund_i[c]);
                end
                end_o <= 1'b1;  // Frame closes on the last sample
                @(posedge clk_i);
                vld_o <= 1'b0;
                end_o <= 1'b0;
            end
        end
    end
endmodule

//--- tb/vha_chk_monitor.sv
// Port assertions for the distortion alarm block
module vha_chk (
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire logic SPEC_END_I,
    input wire logic [3:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [31:0] RDATA_O,
    input wire logic START_O,
    input wire logic ALARM_O,
    input wire logic BLOCKED_O,
    input wire logic IRQ_O
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------
    // Setting shadows and ages since events
    // ------------------------------
    logic [7:0] e_age, c_age, m_age, d_age;
    logic [2:0] mode, msk;
    logic en, dly0;
    function automatic logic [7:0] age(logic hit, logic [7:0] a);
        return hit ? 8'h00 : a + 8'(a != 8'hFF);
    endfunction
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            {e_age, c_age, m_age, d_age} <= 32'hFFFFFFFF;
            {mode, msk, en, dly0} <= 8'h02;
        end else begin
            e_age <= age(SPEC_END_I, e_age);
            c_age <= age(WR_I && ADDR_I == 4'h0, c_age);
            m_age <= age(WR_I && ADDR_I == 4'h5, m_age);
            d_age <= age(WR_I && ADDR_I == 4'h2, d_age);
            if (WR_I && ADDR_I == 4'h0) {en, mode} <= {WDATA_I[4], WDATA_I[2:0]};
            if (WR_I && ADDR_I == 4'h5) msk <= WDATA_I[2:0];
            if (WR_I && ADDR_I == 4'h2) dly0 <= WDATA_I[18:0] == 19'h0;
        end
    end
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RST_N_I);
    // Quiet only well after an evaluation and a settings write; settings move pins only at an evaluation
    sequence s_settled;
        e_age > 8'h80 && c_age > 8'h04;
    endsequence
    sequence s_fast_start;
        dly0 && d_age > 8'h04 && $rose(START_O);
    endsequence
    chk_rd_idle: assert property (!RD_I |=> RDATA_O == 32'h0)
        else $error("read data not zero outside a read");
    chk_start_block: assert property (!(START_O && BLOCKED_O))
        else $error("start and blocked together");
    chk_alarm_start: assert property (ALARM_O |-> START_O)
        else $error("alarm without start");
    chk_release_clear: assert property ($fell(START_O) |-> !ALARM_O)
        else $error("alarm outlived start");
    chk_zero_delay: assert property (s_fast_start |-> ALARM_O)
        else $error("zero delay alarm late");
    chk_quiet_mode: assert property (
        (mode > 3'h1 || !en) && c_age > e_age && e_age > 8'h80 |-> !(START_O || ALARM_O))
        else $error("outputs active while quiet");
    chk_pins_hold: assert property (
        s_settled |-> $stable({START_O, ALARM_O, BLOCKED_O}))
        else $error("outputs moved between evaluations");
    chk_irq_mask: assert property (msk == 3'h0 && m_age > 8'h02 |-> !IRQ_O)
        else $error("interrupt while all masked");
endmodule
bind vha_monitor vha_chk chk (.REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .SPEC_END_I(SPEC_END_I),
    .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .START_O(START_O), .ALARM_O(ALARM_O), .BLOCKED_O(BLOCKED_O), .IRQ_O(IRQ_O));

//--- tb/vha_bench.sv
// Self-checking bench for the distortion alarm block
module vha_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, go, blk, wr, rd_s, vld, eof, so, ao, bo, io;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, stamp, d, lastf;
    vha_pkg::vha_spec_t spec;
    logic [2:0][15:0] fund;
    logic [2:0][31:0] harm;
    logic pw, en, pk, st, al, bl;
    logic [2:0] mode, ist, msk, lastr;
    logic [15:0] fg [3];
    int thr, dly, tmr, fails, checks;
    int cnt [3];
    vha_monitor uut (.REF_CLK_I(clk), .RST_N_I(rst_n), .SPEC_VALID_I(vld), .SPEC_I(spec),
        .SPEC_END_I(eof), .BLOCK_I(blk), .TIME_I(stamp), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd_s), .RDATA_O(rdata), .START_O(so), .ALARM_O(ao),
        .BLOCKED_O(bo), .IRQ_O(io));
    vha_fft_src src (.clk_i(clk), .go_i(go), .fund_i(fund), .harm_i(harm), .vld_o(vld),
        .spec_o(spec), .end_o(eof));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) stamp <= rst_n ? stamp + 32'h1 : 32'h0;
    // ------------------------------
    // Bus, compare and model tasks
    // ------------------------------
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        {wr, addr, wdata} <= {1'b1, a, v};
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        {rd_s, addr} <= {1'b1, a};
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        v = rdata;
    endtask
    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_pin(input logic [3:0] got, input logic [3:0] exp);
        cmp_reg(32'(got), 32'(exp));
    endtask
    task automatic rc(input logic [3:0] a, input logic [31:0] exp);
        rd_reg(a, d);
        cmp_reg(d, exp);
    endtask
    task automatic setc;
        wr_reg(4'h0, {27'h0, en, pw, mode});
    endtask
    function automatic logic [15:0] efig(logic [15:0] f, logic [31:0] h, logic p);
        logic [63:0] q;
        logic [63:0] r;
        if (f == 16'h0) return 16'h0;
        q = (64'(h[31:16]) * h[31:16] + 64'(h[15:0]) * h[15:0]) * 64'h2710 / (64'(f) * f);
        if (q > 64'hFFFF) q = 64'hFFFF;
        r = 64'h0;
        while (!p && (r + 1) * (r + 1) <= q * 64'h2710) r++;
        return p ? q[15:0] : r[15:0];
    endfunction
    task automatic frame(input logic b);
        logic up, hold, nb, ns, na;
        logic [2:0] r;
        @(posedge clk);
        {go, blk} <= {1'b1, b};
        @(posedge clk);
        go <= 1'b0;
        repeat (140) @(posedge clk);
        {up, hold} = 2'h0;
        for (int c = 0; c < 3; c++) begin
            fg[c] = efig(fund[c], harm[c], pw);
            up |= fg[c] > thr;
            hold |= fg[c] * 32'h64 >= thr * 32'h61;
        end
        pk = mode < 3'h4 && en && (pk ? hold : up);
        nb = pk && (blk || mode[0]);
        ns = pk && !nb;
        na = ns && tmr >= dly;
        tmr = ns ? tmr + 1 : 0;
        r = {nb & !bl, na & !al, ns & !st};
        {bl, al, st} = {nb, na, ns};
        ist |= r;
        for (int k = 0; k < 3; k++) cnt[k] += r[k];
        if (r != 3'h0) {lastr, lastf} = {r, fg[1], fg[0]};
        @(negedge clk);
        cmp_pin({so, ao, bo, io}, {{st, al, bl} & {3{mode < 3'h2}}, |(ist & msk)});
        rc(4'hA, {fg[1], fg[0]});
        rd_reg(4'hB, d);
        cmp_reg(d & 32'hFFFF, 32'(fg[2]));
        rd_reg(4'h3, d);
        cmp_reg(d & 32'h7, {29'h0, pk, bl ? 2'h3 : (al ? 2'h2 : {1'b0, st})});
    endtask
    task automatic results;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        fails++;
        results();
    end
    // ------------------------------
    // Main sequence
    // ------------------------------
    initial begin
        {rst_n, go, blk, wr, rd_s, addr, wdata, lastf, fund, harm} = '0;
        {pk, st, al, bl, pw, ist, msk, lastr, mode, tmr, fails, checks} = '0;
        {en, thr, dly} = {1'b1, 32'd1000, 32'd2000};
        cnt = '{0, 0, 0};
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        void'($urandom(32'h6f08cbf4));
        rc(4'h0, 32'h10);
        rc(4'h1, 32'h3E8);
        rc(4'h2, 32'h7D0);
        wr_reg(4'h1, 32'h5);
        rc(4'h1, 32'hA);
        wr_reg(4'h1, 32'h4E21);
        rc(4'h1, 32'h2710);
        wr_reg(4'h5, 32'h7);
        msk = 3'h7;
        for (int i = 0; i < 8; i++) begin
            pw = i[0];
            thr = 10 + $urandom_range(2990);
            for (int c = 0; c < 3; c++) begin
                fund[c] = 16'(2000 + $urandom_range(2000));
                harm[c] = {16'($urandom_range(1000)), 16'($urandom_range(1000))};
            end
            if (i == 7) fund[2] = 16'h0;
            setc();
            wr_reg(4'h1, 32'(thr));
            frame(1'b0);
        end
        {pw, thr, dly, fund} = {1'b1, 32'd1000, 32'd0, {3{16'h0064}}};
        setc();
        wr_reg(4'h1, 32'h3E8);
        wr_reg(4'h2, 32'h0);
        // Just above, exactly at the release ratio, just below: one phase each
        for (int k = 0; k < 3; k++) begin
            harm = '0;
            harm[k] = k == 0 ? 32'h00200001 : (k == 1 ? 32'h001F0003 : 32'h00160016);
            frame(1'b0);
        end
        rc(4'h4, {29'h0, ist});
        ist = 3'h0;
        harm = {3{32'h00200001}};
        frame(1'b1);
        frame(1'b0);
        wr_reg(4'h5, 32'h0);
        msk = 3'h0;
        for (int m = 0; m < 6; m++) begin
            {mode, en} = {3'(m % 5), m < 5};
            setc();
            harm = {3{32'h00200001}};
            frame(1'b0);
            harm = '0;
            frame(1'b0);
        end
        rc(4'h6, 32'(cnt[0]));
        rc(4'h7, 32'(cnt[1]));
        rc(4'h8, 32'(cnt[2]));
        rd_reg(4'hE, d);
        cmp_reg(d & 32'h7, 32'(lastr));
        rc(4'hF, lastf);
        wr_reg(4'h9, 32'h0);
        rc(4'h6, 32'h0);
        results();
    end
endmodule
